// ===== logic/oirp_ram_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "oirp_map.svh"
module oirp_ram_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration write of the RAM base register
  input wire logic cfg_base_wr_i,
  input wire logic [31:0] cfg_base_wdata_i,
  output logic [31:0] cfg_base_o,
  // Chip-test control and general register B
  input wire logic chip_test_ctl_two_wr_i,
  input wire logic [7:0] chip_test_ctl_two_wdata_i,
  input wire logic general_reg_b_wr_i,
  input wire logic [31:0] general_reg_b_wdata_i,
  output logic [31:0] general_reg_b_rdata_o,
  // Bus target port
  input wire logic tgt_req_i,
  input wire oirp_pkg::oirp_req_t tgt_cmd_i,
  output logic tgt_hit_o,
  output logic tgt_ack_o,
  output logic [31:0] tgt_rdata_o,
  // Embedded processor fetch port
  input wire logic cpu_req_i,
  input wire oirp_pkg::oirp_kind_t cpu_kind_i,
  input wire logic [31:0] cpu_addr_i,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  output logic cpu_to_bus_o
);
  logic [31:0] base_reg;
  logic [7:0] ctl_reg;
  logic [31:0] genb_reg;
  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  oirp_pkg::oirp_state_t state_reg;
  oirp_pkg::oirp_req_t cmd_reg;
  logic tgt_hit;
  logic cpu_hit;
  logic cpu_local;
  logic [`OIRP_RAM_AW-1:0] tgt_idx;
  logic [`OIRP_RAM_AW-1:0] cpu_idx;
  logic [31:0] tgt_word;
  logic [31:0] cpu_word;

  // Decode against the relocatable base; disabled base claims nothing
  assign tgt_hit = base_reg[`OIRP_BASE_EN_BIT]
    && ((tgt_cmd_i.addr & `OIRP_BASE_MASK) == (base_reg & `OIRP_BASE_MASK));
  assign cpu_hit = base_reg[`OIRP_BASE_EN_BIT]
    && ((cpu_addr_i & `OIRP_BASE_MASK) == (base_reg & `OIRP_BASE_MASK));
  // Only fetches stay inside; data moves must look like any external memory
  assign cpu_local = cpu_hit && (cpu_kind_i != oirp_pkg::OIRP_K_DATA);
  assign cpu_to_bus_o = cpu_req_i && !cpu_local;
  assign tgt_hit_o = tgt_req_i && tgt_hit;
  assign tgt_idx = cmd_reg.addr[`OIRP_RAM_AW+1:2];
  assign cpu_idx = cpu_addr_i[`OIRP_RAM_AW+1:2];
  assign cfg_base_o = base_reg;

  // Base register: read-only zeros below the alignment except enable bit 0, like a ROM base
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      base_reg <= `OIRP_BASE_RST;
    end else if (cfg_base_wr_i) begin
      base_reg <= cfg_base_wdata_i & (`OIRP_BASE_MASK | 32'h00000001);
    end
  end

  // Chip-test control and general register B storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_reg <= `OIRP_CTL_RST;
      genb_reg <= `OIRP_GENB_RST;
    end else begin
      if (chip_test_ctl_two_wr_i) begin
        ctl_reg <= chip_test_ctl_two_wdata_i;
      end
      if (general_reg_b_wr_i) begin
        genb_reg <= general_reg_b_wdata_i;
      end
    end
  end

  // Read mux flopped so the value follows the control bit one edge later
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      general_reg_b_rdata_o <= `OIRP_GENB_RST;
    end else if (ctl_reg[`OIRP_CTL_BASE_BIT]) begin
      general_reg_b_rdata_o <= base_reg & `OIRP_BASE_MASK;
    end else begin
      general_reg_b_rdata_o <= genb_reg;
    end
  end

  // Wait counter next value
  always_comb begin
    wait_next = wait_reg;
    if (state_reg == oirp_pkg::OIRP_S_WAIT) begin
      wait_next = wait_reg - 3'h1;
    end
  end

  // Target sequence: take, hold 3 wait states, then complete
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= oirp_pkg::OIRP_S_IDLE;
      wait_reg <= 3'h0;
      cmd_reg <= '0;
    end else begin
      case (state_reg)
        oirp_pkg::OIRP_S_IDLE: begin
          if (tgt_req_i && tgt_hit) begin
            cmd_reg <= tgt_cmd_i;
            wait_reg <= 3'(`OIRP_RAM_WAIT - 1);
            state_reg <= oirp_pkg::OIRP_S_WAIT;
          end
        end
        oirp_pkg::OIRP_S_WAIT: begin
          wait_reg <= wait_next;
          if (wait_reg == 3'h0) begin
            state_reg <= oirp_pkg::OIRP_S_DONE;
          end
        end
        oirp_pkg::OIRP_S_DONE: begin
          state_reg <= oirp_pkg::OIRP_S_IDLE;
        end
        default: begin
          state_reg <= oirp_pkg::OIRP_S_IDLE;
        end
      endcase
    end
  end
  assign tgt_ack_o = (state_reg == oirp_pkg::OIRP_S_DONE);

  // Byte-lane storage; a memory copy lands here as ordinary target writes
  // Each lane owns its array so that no two processes write one variable
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane_mem [0:`OIRP_RAM_WORDS-1];
    always_ff @(posedge clk_i) begin
      if (state_reg == oirp_pkg::OIRP_S_DONE && cmd_reg.wr && cmd_reg.be[b]) begin
        lane_mem[tgt_idx] <= cmd_reg.wdata[8*b +: 8];
      end
    end
    assign tgt_word[8*b +: 8] = lane_mem[tgt_idx];
    assign cpu_word[8*b +: 8] = lane_mem[cpu_idx];
  end

  // Target read data, captured during the last wait state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tgt_rdata_o <= 32'h00000000;
    end else if (state_reg == oirp_pkg::OIRP_S_WAIT && wait_reg == 3'h0 && !cmd_reg.wr) begin
      tgt_rdata_o <= tgt_word;
    end
  end

  // Internal fetch path: answer next cycle, no bus involvement
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cpu_ack_o <= 1'b0;
      cpu_rdata_o <= 32'h00000000;
    end else begin
      cpu_ack_o <= cpu_req_i && cpu_local;
      if (cpu_req_i && cpu_local) begin
        cpu_rdata_o <= cpu_word;
      end
    end
  end

  // Assertions
  local_fetch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cpu_req_i && cpu_local |-> !cpu_to_bus_o ##1 cpu_ack_o)
    else $error("local fetch went to bus");
  data_bus_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cpu_req_i && cpu_kind_i == oirp_pkg::OIRP_K_DATA |-> cpu_to_bus_o)
    else $error("data access not on bus");
  base_decode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_req_i && !base_reg[0] |-> !tgt_hit_o)
    else $error("disabled base claimed");
  base_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (base_reg & 32'h00000FFE) == 32'h0)
    else $error("base low bits set");
  genb_base_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctl_reg[`OIRP_CTL_BASE_BIT] |=> general_reg_b_rdata_o == ($past(base_reg) & `OIRP_BASE_MASK))
    else $error("base not reported");
  genb_plain_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctl_reg[3] && !general_reg_b_wr_i |=> general_reg_b_rdata_o == $past(genb_reg))
    else $error("ordinary contents lost");
  wait_three_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    state_reg == oirp_pkg::OIRP_S_IDLE && tgt_req_i && tgt_hit |=> !tgt_ack_o [*3] ##1 tgt_ack_o)
    else $error("wrong wait count");
  byte_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_ack_o && cmd_reg.wr && cmd_reg.be[0] |=> tgt_word[7:0] == $past(cmd_reg.wdata[7:0]))
    else $error("byte not written");
  byte_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_ack_o && cmd_reg.wr && !cmd_reg.be[0] |=> tgt_word[7:0] == $past(tgt_word[7:0]))
    else $error("unselected byte changed");
  read_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_ack_o && !cmd_reg.wr |-> tgt_rdata_o == $past(tgt_word))
    else $error("read data not the addressed word");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tgt_ack_o |=> !tgt_ack_o)
    else $error("acknowledge held too long");
  fetch_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cpu_req_i && cpu_local |=> cpu_rdata_o == $past(cpu_word))
    else $error("fetch data not the addressed word");
  base_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_base_wr_i |=> base_reg == ($past(cfg_base_wdata_i) & (`OIRP_BASE_MASK | 32'h00000001)))
    else $error("base write not taken");
  cov_read_c: cover property (@(posedge clk_i) tgt_ack_o && !cmd_reg.wr);
  cov_write_c: cover property (@(posedge clk_i) tgt_ack_o && cmd_reg.wr);
  cov_fetch_c: cover property (@(posedge clk_i) cpu_ack_o);
  cov_report_c: cover property (@(posedge clk_i) ctl_reg[3] ##1 !ctl_reg[3]);
endmodule : oirp_ram_port
`default_nettype wire

// ===== inc/oirp_map.svh
`ifndef OIRP_MAP_SVH
`define OIRP_MAP_SVH
// RAM geometry: 4 KB of 32-bit words
`define OIRP_RAM_WORDS 1024
`define OIRP_RAM_AW 10
// Base register: 4 KB aligned, low bits read as zero, bit 0 is the decode enable
`define OIRP_BASE_MASK 32'hFFFFF000
`define OIRP_BASE_EN_BIT 0
`define OIRP_BASE_RST 32'h00000000
// Base-reporting bit in the chip-test control register
`define OIRP_CTL_BASE_BIT 3
`define OIRP_CTL_RST 8'h00
`define OIRP_GENB_RST 32'h00000000
// Target wait states
`define OIRP_RAM_WAIT 3
`define OIRP_REG_WAIT 5
`endif

// ===== inc/oirp_pkg.sv
package oirp_pkg;
  // One target access
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
  } oirp_req_t;
  // Processor access kind
  typedef enum logic [1:0] {
    OIRP_K_INSTR = 2'h0,
    OIRP_K_TABLE = 2'h1,
    OIRP_K_DATA = 2'h2
  } oirp_kind_t;
  // Target port states
  typedef enum logic [2:0] {
    OIRP_S_IDLE = 3'h1,
    OIRP_S_WAIT = 3'h2,
    OIRP_S_DONE = 3'h4
  } oirp_state_t;
endpackage : oirp_pkg

// ===== bench/oirp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host bus master: holds a request until the target acknowledges it
module oirp_host_model (
  // Clock, reset and bench control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire oirp_pkg::oirp_req_t cmd_i,
  // Target port
  input wire logic tgt_ack_i,
  input wire logic [31:0] tgt_rdata_i,
  output logic tgt_req_o,
  output oirp_pkg::oirp_req_t tgt_cmd_o,
  // Results of the last transfer
  output logic [31:0] rdata_o,
  output logic [3:0] lat_o
);
  logic [3:0] cnt_reg;
  // Released command is inverted, so stale values never pass for a live request
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tgt_req_o <= 1'b0;
      tgt_cmd_o <= '0;
      cnt_reg <= 4'h0;
    end else if (tgt_req_o && tgt_ack_i) begin
      tgt_req_o <= 1'b0;
      tgt_cmd_o <= ~tgt_cmd_o;
      rdata_o <= tgt_rdata_i;
      lat_o <= cnt_reg;
    end else if (go_i && !tgt_req_o) begin
      tgt_req_o <= 1'b1;
      tgt_cmd_o <= cmd_i;
      cnt_reg <= 4'h0;
    end else if (tgt_req_o) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : oirp_host_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_n_i, go, cbw, ctw, gbw, req, ack, hit, cpu_req, cpu_ack, to_bus;
  logic [31:0] cbd, cbo, gbd, gbo, trd, mrd, crd, cpu_addr;
  logic [7:0] ctd;
  logic [3:0] lat;
  oirp_pkg::oirp_req_t cmd, tcmd;
  oirp_pkg::oirp_kind_t kind;
  int error_cnt = 0;
  int compares = 0;
  oirp_ram_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_base_wr_i(cbw), .cfg_base_wdata_i(cbd),
    .cfg_base_o(cbo), .chip_test_ctl_two_wr_i(ctw), .chip_test_ctl_two_wdata_i(ctd),
    .general_reg_b_wr_i(gbw), .general_reg_b_wdata_i(gbd), .general_reg_b_rdata_o(gbo),
    .tgt_req_i(req), .tgt_cmd_i(tcmd), .tgt_hit_o(hit), .tgt_ack_o(ack), .tgt_rdata_o(trd),
    .cpu_req_i(cpu_req), .cpu_kind_i(kind), .cpu_addr_i(cpu_addr), .cpu_ack_o(cpu_ack),
    .cpu_rdata_o(crd), .cpu_to_bus_o(to_bus));
  oirp_host_model u_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .cmd_i(cmd), .tgt_ack_i(ack),
    .tgt_rdata_i(trd), .tgt_req_o(req), .tgt_cmd_o(tcmd), .rdata_o(mrd), .lat_o(lat));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  // Register pulse: 0 base, 1 control, 2 general register B
  task automatic wreg(input int sel, input logic [31:0] d);
    @(posedge clk_i);
    {cbw, ctw, gbw} <= {sel == 0, sel == 1, sel == 2};
    {cbd, ctd, gbd} <= {d, d[7:0], d};
    @(posedge clk_i);
    {cbw, ctw, gbw} <= 3'h0;
    @(posedge clk_i);
    #1;
  endtask : wreg
  // Bounded wait for the host to see its acknowledge; a hang ends the run
  task automatic wait_done;
    for (int i = 0; i < 20 && req; i++) @(posedge clk_i) #1;
    if (req) begin
      $display("ERROR %0t no acknowledge from target", $time);
      error_cnt++;
      print_verdict();
    end
  endtask : wait_done
  // One target transfer through the host model
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be, input logic wr);
    @(posedge clk_i);
    go <= 1'b1;
    cmd <= '{addr: a, wdata: d, be: be, wr: wr};
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i) #1;
    chk(hit, 1'b1);
    wait_done();
    chk(lat, 4'h4);
  endtask : xfer
  task automatic t_ram;
    wreg(0, 32'h12345679);
    chk(cbo, 32'h12345001);
    xfer(32'h12345008, 32'h11223344, 4'hF, 1'b1);
    xfer(32'h12345008, 32'hAABBCCDD, 4'h2, 1'b1);
    xfer(32'h12345008, 32'h0, 4'hF, 1'b0);
    chk(mrd, 32'h1122CC44);
  endtask : t_ram
  // Processor fetch: local kinds inside the base are answered in one cycle, the rest go to the bus
  task automatic t_fetch(input oirp_pkg::oirp_kind_t k, input logic [31:0] a, input logic bus);
    @(posedge clk_i);
    cpu_req <= 1'b1;
    kind <= k;
    cpu_addr <= a;
    #1;
    chk(to_bus, bus);
    @(posedge clk_i);
    cpu_req <= 1'b0;
    #1;
    chk(cpu_ack, !bus);
    if (!bus) chk(crd, 32'h1122CC44);
  endtask : t_fetch
  // Software reads the base back and patches it into an absolute address
  task automatic t_scratch;
    wreg(2, 32'hCAFE0001);
    chk(gbo, 32'hCAFE0001);
    wreg(1, 32'h08);
    chk(gbo, 32'h12345000);
    xfer(gbo + 32'h00000008, 32'h0, 4'hF, 1'b0);
    chk(mrd, 32'h1122CC44);
    wreg(1, 32'h00);
    chk(gbo, 32'hCAFE0001);
  endtask : t_scratch
  // A miss is never claimed; the host waits on, so a reset mid-run clears both sides
  task automatic t_miss;
    @(posedge clk_i);
    go <= 1'b1;
    cmd <= '{addr: 32'h12346008, wdata: 32'h0, be: 4'hF, wr: 1'b0};
    @(posedge clk_i);
    go <= 1'b0;
    repeat (6) begin
      @(posedge clk_i) #1;
      chk(hit, 1'b0);
      chk(ack, 1'b0);
    end
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i) #1;
    chk(cbo, 32'h0);
    chk(gbo, 32'h0);
  endtask : t_miss
  // A disabled base claims nothing; enabling it lets the waiting write through
  task automatic t_enable;
    wreg(0, 32'h12345000);
    @(posedge clk_i);
    go <= 1'b1;
    cmd <= '{addr: 32'h12345008, wdata: 32'h55667788, be: 4'hF, wr: 1'b1};
    @(posedge clk_i);
    go <= 1'b0;
    repeat (3) begin
      @(posedge clk_i) #1;
      chk(hit, 1'b0);
    end
    wreg(0, 32'h12345001);
    wait_done();
    chk(cbo, 32'h12345001);
  endtask : t_enable
  // Same image at a new base: offsets inside it still land on the same word
  task automatic t_reloc;
    wreg(0, 32'hABCDE001);
    chk(cbo, 32'hABCDE001);
    xfer(32'hABCDE008, 32'h0, 4'hF, 1'b0);
    chk(mrd, 32'h55667788);
  endtask : t_reloc
  initial begin
    {rst_n_i, go, cbw, ctw, gbw, cpu_req} = 6'h0;
    {cbd, gbd, cpu_addr, ctd} = '0;
    cmd = '0;
    kind = oirp_pkg::OIRP_K_INSTR;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk(cbo, 32'h0);
    t_ram();
    t_fetch(oirp_pkg::OIRP_K_INSTR, 32'h12345008, 1'b0);
    t_fetch(oirp_pkg::OIRP_K_TABLE, 32'h12345008, 1'b0);
    t_fetch(oirp_pkg::OIRP_K_DATA, 32'h12345008, 1'b1);
    t_fetch(oirp_pkg::OIRP_K_INSTR, 32'h00100008, 1'b1);
    t_scratch();
    t_miss();
    t_enable();
    t_reloc();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
